// File: rtl/nand_host_pkg.sv
package nand_host_pkg;

    localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_CACHE_CONF   = 8'h31;
    localparam logic [7:0] CMD_CACHE_EXIT   = 8'h34;
    localparam logic [7:0] CMD_COPY_CONF    = 8'h35;
    localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
    localparam logic [7:0] CMD_RAND_OUT_CF  = 8'he0;
    localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
    localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_RAND_IN      = 8'h85;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;

    localparam int PAGE_BYTES = 2112;
    localparam int PAGE_WORDS = 1056;
    localparam int COL_W      = 12;
    localparam int ROW_W      = 17;
    localparam int MAX_PARTIAL = 4;

    localparam int STAT_FAIL_BIT  = 0;
    localparam int STAT_CTRL_BIT  = 5;
    localparam int STAT_CACHE_BIT = 6;

    localparam int STROBE_LOW_NS  = 20;
    localparam int STROBE_HIGH_NS = 20;
    localparam int CLK_NS         = 10;
    localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [3:0] {
        OP_READ       = 4'h0,
        OP_CACHE_READ = 4'h1,
        OP_CACHE_EXIT = 4'h2,
        OP_RAND_OUT   = 4'h3,
        OP_PROGRAM    = 4'h4,
        OP_RAND_IN    = 4'h5,
        OP_COPY_BACK  = 4'h6,
        OP_STATUS     = 4'h7
    } op_t;

    typedef struct packed {
        op_t              op;
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
        logic [ROW_W-1:0] dst_row;
        logic [11:0]      count;
        logic             five_addr;
        logic             wide;
    } req_t;

    typedef struct packed {
        logic        cle;
        logic        ale;
        logic        we_n;
        logic        re_n;
        logic [15:0] dq_out;
        logic        dq_oe;
    } pins_t;

    typedef enum logic [1:0] {
        CYC_CMD  = 2'h0,
        CYC_ADDR = 2'h1,
        CYC_WR   = 2'h2,
        CYC_RD   = 2'h3
    } cyc_t;

endpackage

// File: rtl/nand_bus_cycle.sv
`timescale 1ns/1ns
module nand_bus_cycle
    import nand_host_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  nand_host_pkg::cyc_t kind,
    input  wire logic [15:0] wdata,
    input  wire logic [15:0] dq_sync,
    output logic             done,
    output logic [15:0]      rdata,
    output nand_host_pkg::pins_t pins
);
    // One strobed bus cycle: strobe low phase, then high phase.
    typedef enum logic [2:0] {
        B_IDLE = 3'b001,
        B_LOW  = 3'b010,
        B_HIGH = 3'b100
    } bst_t;

    bst_t         st_r, st_nxt;
    cyc_t         kind_r, kind_nxt;
    logic [15:0]  wd_r, wd_nxt, rd_r, rd_nxt;
    logic [3:0]   cnt_r, cnt_nxt;

    always_comb begin
        st_nxt   = st_r;
        kind_nxt = kind_r;
        wd_nxt   = wd_r;
        rd_nxt   = rd_r;
        cnt_nxt  = cnt_r;
        done     = 1'b0;
        unique case (st_r)
            B_IDLE: begin
                if (start) begin
                    st_nxt   = B_LOW;
                    kind_nxt = kind;
                    wd_nxt   = wdata;
                    cnt_nxt  = 4'(STROBE_LOW_CYC);
                end
            end
            B_LOW: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    st_nxt  = B_HIGH;
                    cnt_nxt = 4'(STROBE_HIGH_CYC);
                end
            end
            B_HIGH: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'(STROBE_HIGH_CYC) && kind_r == CYC_RD) begin
                    rd_nxt = dq_sync;
                end
                if (cnt_r == 4'h1) begin
                    st_nxt = B_IDLE;
                    done   = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r   <= B_IDLE;
            kind_r <= CYC_CMD;
            wd_r   <= 16'h0000;
            rd_r   <= 16'h0000;
            cnt_r  <= 4'h0;
        end else begin
            st_r   <= st_nxt;
            kind_r <= kind_nxt;
            wd_r   <= wd_nxt;
            rd_r   <= rd_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    assign rdata       = rd_r;
    assign pins.cle    = (st_r != B_IDLE) && (kind_r == CYC_CMD);
    assign pins.ale    = (st_r != B_IDLE) && (kind_r == CYC_ADDR);
    assign pins.we_n   = !((st_r == B_LOW) && (kind_r != CYC_RD));
    assign pins.re_n   = !((st_r == B_LOW) && (kind_r == CYC_RD));
    assign pins.dq_out = wd_r;
    assign pins.dq_oe  = (st_r != B_IDLE) && (kind_r != CYC_RD);
endmodule

// File: rtl/nand_pin_sync.sv
`timescale 1ns/1ns
module nand_pin_sync #(
    parameter int W = 17
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    // Two-flop synchroniser for device pins.
    logic [W-1:0] s1_r, s2_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    assign q = s2_r;
endmodule

// File: rtl/nand_page_op_sequencer.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Function
// - Each read strobe returns next column word.
// - Cache read: setup, address, confirm 31h.
// - Cache read start column is zero.
// - Cache read ends with exit command.
// - At most four partial programs per page; the count restarts when a program request to another page completes in between (copy back leaves it).
// - Sequential input stays inside one block.
// - Program: setup, address, data, confirm.
// - Random input: 85h plus two column cycles.
// - Copy back: read source, wait, program target.
// - Copy back keeps top block bit equal.
// - Copy back failure read from status.
// - Read 00h/30h, cache 00h/31h, exit 34h.
// - Program 80h/10h, random input 85h, copy 35h.
// - Commands on low byte; random output 05h/E0h.
// - Two column cycles, then row cycles.
module nand_page_op_sequencer
    import nand_host_pkg::*;
#(
    parameter int PART_LIMIT = MAX_PARTIAL
) (
    input  wire logic            clock,
    input  wire logic            sys_rst,
    input  nand_host_pkg::req_t  req,
    input  wire logic            req_valid,
    output logic                 req_ready,
    output logic                 req_error,
    input  wire logic [15:0]     wr_data,
    input  wire logic            wr_valid,
    output logic                 wr_ready,
    output logic [15:0]          rd_data,
    output logic                 rd_valid,
    input  wire logic            rd_ready,
    output logic [7:0]           status,
    output logic                 status_valid,
    output logic                 busy,
    output nand_host_pkg::pins_t pins,
    input  wire logic [15:0]     dq_in,
    input  wire logic            ready_busy_n
);
    import nand_host_pkg::*;

    typedef enum logic [11:0] {
        S_IDLE   = 12'h001,
        S_CMD1   = 12'h002,
        S_ADDR   = 12'h004,
        S_CMD2   = 12'h008,
        S_WAIT   = 12'h010,
        S_DATA   = 12'h020,
        S_CMD3   = 12'h040,
        S_RADDR  = 12'h080,
        S_CMD4   = 12'h100,
        S_STCMD  = 12'h200,
        S_STRD   = 12'h400,
        S_DONE   = 12'h800
    } st_t;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic [16:0] pin_raw, pin_s;
    logic [15:0] dq_sync;
    logic        rb_sync;

    assign pin_raw = {ready_busy_n, dq_in};

    nand_pin_sync #(.W(17)) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .d       (pin_raw),
        .q       (pin_s)
    );

    assign dq_sync = pin_s[15:0];
    assign rb_sync = pin_s[16];

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle engine.
    logic        cyc_start, cyc_done;
    cyc_t        cyc_kind;
    logic [15:0] cyc_wdata, cyc_rdata;

    nand_bus_cycle u_cyc (
        .clock   (clock),
        .sys_rst (sys_rst),
        .start   (cyc_start),
        .kind    (cyc_kind),
        .wdata   (cyc_wdata),
        .dq_sync (dq_sync),
        .done    (cyc_done),
        .rdata   (cyc_rdata),
        .pins    (pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state.
    st_t          st_r, st_nxt;
    req_t         rq_r, rq_nxt;
    logic [2:0]   idx_r, idx_nxt;
    logic [11:0]  cnt_r, cnt_nxt;
    logic         issued_r, issued_nxt;
    logic         cache_r, cache_nxt;
    logic [7:0]   stat_r, stat_nxt;
    logic         err_r, err_nxt;
    logic [15:0]  rdd_r, rdd_nxt;
    logic         rdv_r, rdv_nxt;
    logic [ROW_W-1:0] prow_r, prow_nxt;
    logic [2:0]   pcnt_r, pcnt_nxt;

    // Address byte n of a column/row pair; top byte carries the top block bit.
    function automatic logic [7:0] addr_byte(input logic [COL_W-1:0] c,
                                             input logic [ROW_W-1:0] r,
                                             input logic [2:0] n);
        logic [7:0] b;
        b = 8'h00;
        unique case (n)
            3'h0: b = c[7:0];
            3'h1: b = {4'h0, c[11:8]};
            3'h2: b = r[7:0];
            3'h3: b = r[15:8];
            default: b = {7'h00, r[16]};
        endcase
        return b;
    endfunction

    function automatic logic [2:0] addr_last(input logic five);
        return five ? 3'h4 : 3'h3;
    endfunction

    logic [ROW_W-1:0] cur_row;
    logic             is_prog;
    assign cur_row = (rq_r.op == OP_COPY_BACK && issued_r) ? rq_r.dst_row : rq_r.row;
    assign is_prog = (rq_r.op == OP_PROGRAM) || (rq_r.op == OP_COPY_BACK);

    always_comb begin
        st_nxt     = st_r;
        rq_nxt     = rq_r;
        idx_nxt    = idx_r;
        cnt_nxt    = cnt_r;
        issued_nxt = issued_r;
        cache_nxt  = cache_r;
        stat_nxt   = stat_r;
        err_nxt    = 1'b0;
        rdd_nxt    = rdd_r;
        rdv_nxt    = rdv_r && !rd_ready;
        prow_nxt   = prow_r;
        pcnt_nxt   = pcnt_r;
        cyc_start  = 1'b0;
        cyc_kind   = CYC_CMD;
        cyc_wdata  = 16'h0000;
        wr_ready   = 1'b0;
        unique case (st_r)
            S_IDLE: begin
                if (req_valid) begin
                    rq_nxt     = req;
                    idx_nxt    = 3'h0;
                    issued_nxt = 1'b0;
                    st_nxt     = S_CMD1;
                    if (req.op == OP_RAND_OUT && cache_r) begin
                        err_nxt = 1'b1;
                        st_nxt  = S_IDLE;
                    end
                    if (req.op == OP_CACHE_READ && req.col != '0) begin
                        err_nxt = 1'b1;
                        st_nxt  = S_IDLE;
                    end
                    if (req.op == OP_PROGRAM) begin
                        if (req.count == '0 || req.count > 12'(PAGE_BYTES)
                            || (req.wide && req.count > 12'(PAGE_WORDS))) begin
                            err_nxt = 1'b1;
                            st_nxt  = S_IDLE;
                        end else if (req.row == prow_r
                                     && pcnt_r >= 3'(PART_LIMIT)) begin
                            err_nxt = 1'b1;
                            st_nxt  = S_IDLE;
                        end
                    end
                    if (req.op == OP_COPY_BACK && req.five_addr
                        && req.row[ROW_W-1] != req.dst_row[ROW_W-1]) begin
                        err_nxt = 1'b1;
                        st_nxt  = S_IDLE;
                    end
                end
            end
            S_CMD1: begin
                cyc_start = 1'b1;
                cyc_kind  = CYC_CMD;
                unique case (rq_r.op)
                    OP_RAND_OUT:   cyc_wdata = {8'h00, CMD_RAND_OUT};
                    OP_PROGRAM:    cyc_wdata = {8'h00, CMD_PROG_SETUP};
                    OP_RAND_IN:    cyc_wdata = {8'h00, CMD_RAND_IN};
                    OP_CACHE_EXIT: cyc_wdata = {8'h00, CMD_CACHE_EXIT};
                    OP_STATUS:     cyc_wdata = {8'h00, CMD_READ_STATUS};
                    OP_COPY_BACK:  cyc_wdata = issued_r ? {8'h00, CMD_RAND_IN}
                                                        : {8'h00, CMD_READ_SETUP};
                    default:       cyc_wdata = {8'h00, CMD_READ_SETUP};
                endcase
                if (cyc_done) begin
                    cyc_start = 1'b0;
                    if (rq_r.op == OP_CACHE_EXIT) begin
                        cache_nxt = 1'b0;
                        cnt_nxt   = 12'h003;
                        st_nxt    = S_WAIT;
                    end else if (rq_r.op == OP_STATUS) begin
                        st_nxt = S_STRD;
                    end else begin
                        st_nxt = S_ADDR;
                    end
                end
            end
            S_ADDR: begin
                cyc_start = 1'b1;
                cyc_kind  = CYC_ADDR;
                cyc_wdata = {8'h00, addr_byte(rq_r.col, cur_row, idx_r)};
                if (cyc_done) begin
                    cyc_start = 1'b0;
                    idx_nxt   = idx_r + 3'h1;
                    if (rq_r.op == OP_RAND_OUT || rq_r.op == OP_RAND_IN) begin
                        if (idx_r == 3'h1) begin
                            st_nxt = (rq_r.op == OP_RAND_IN) ? S_DATA : S_CMD2;
                        end
                    end else if (idx_r == addr_last(rq_r.five_addr)) begin
                        st_nxt = (rq_r.op == OP_PROGRAM
                                  || (rq_r.op == OP_COPY_BACK && issued_r))
                                 ? S_DATA : S_CMD2;
                    end
                    cnt_nxt = rq_r.count;
                end
            end
            S_DATA: begin
                if (cnt_r == '0) begin
                    st_nxt = is_prog ? S_CMD2 : S_DONE;
                end else begin
                    wr_ready  = cyc_done;
                    cyc_start = wr_valid && !cyc_done;
                    cyc_kind  = CYC_WR;
                    cyc_wdata = wr_data;
                    if (cyc_done) begin
                        cnt_nxt = cnt_r - 12'h001;
                    end
                end
            end
            S_CMD2: begin
                cyc_start = 1'b1;
                cyc_kind  = CYC_CMD;
                unique case (rq_r.op)
                    OP_RAND_OUT:   cyc_wdata = {8'h00, CMD_RAND_OUT_CF};
                    OP_CACHE_READ: cyc_wdata = {8'h00, CMD_CACHE_CONF};
                    OP_PROGRAM:    cyc_wdata = {8'h00, CMD_PROG_CONFIRM};
                    OP_COPY_BACK:  cyc_wdata = issued_r ? {8'h00, CMD_PROG_CONFIRM}
                                                        : {8'h00, CMD_COPY_CONF};
                    default:       cyc_wdata = {8'h00, CMD_READ_CONFIRM};
                endcase
                if (cyc_done) begin
                    cyc_start = 1'b0;
                    cnt_nxt   = 12'h003;
                    if (rq_r.op == OP_CACHE_READ) begin
                        cache_nxt = 1'b1;
                    end
                    st_nxt = (rq_r.op == OP_RAND_OUT) ? S_CMD3 : S_WAIT;
                end
            end
            S_WAIT: begin
                // Allow the device time to drop its busy line before watching it.
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 12'h001;
                end else if (rb_sync) begin
                    if (rq_r.op == OP_COPY_BACK && !issued_r) begin
                        issued_nxt = 1'b1;
                        idx_nxt    = 3'h0;
                        cnt_nxt    = '0;
                        st_nxt     = S_CMD1;
                    end else if (is_prog) begin
                        st_nxt = S_STCMD;
                    end else begin
                        st_nxt = S_CMD3;
                    end
                end
            end
            S_CMD3: begin
                cnt_nxt = rq_r.count;
                st_nxt  = S_CMD4;
                if (rq_r.op == OP_CACHE_EXIT) begin
                    st_nxt = S_DONE;
                end
            end
            S_CMD4: begin
                if (cnt_r == '0) begin
                    st_nxt = S_DONE;
                end else if (!rdv_r || rd_ready) begin
                    cyc_start = !cyc_done;
                    cyc_kind  = CYC_RD;
                    if (cyc_done) begin
                        cyc_start = 1'b0;
                        rdd_nxt   = cyc_rdata;
                        rdv_nxt   = 1'b1;
                        cnt_nxt   = cnt_r - 12'h001;
                    end
                end
            end
            S_STCMD: begin
                cyc_start = 1'b1;
                cyc_kind  = CYC_CMD;
                cyc_wdata = {8'h00, CMD_READ_STATUS};
                if (cyc_done) begin
                    cyc_start = 1'b0;
                    st_nxt    = S_STRD;
                end
            end
            S_STRD: begin
                cyc_start = !cyc_done;
                cyc_kind  = CYC_RD;
                if (cyc_done) begin
                    cyc_start = 1'b0;
                    stat_nxt  = cyc_rdata[7:0];
                    if (rq_r.op == OP_PROGRAM) begin
                        pcnt_nxt = (rq_r.row == prow_r) ? pcnt_r + 3'h1 : 3'h1;
                        prow_nxt = rq_r.row;
                    end
                    st_nxt = S_DONE;
                end
            end
            S_DONE: begin
                st_nxt = S_IDLE;
            end
            default: begin
                st_nxt = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r     <= S_IDLE;
            rq_r     <= '0;
            idx_r    <= 3'h0;
            cnt_r    <= 12'h000;
            issued_r <= 1'b0;
            cache_r  <= 1'b0;
            stat_r   <= 8'h00;
            err_r    <= 1'b0;
            rdd_r    <= 16'h0000;
            rdv_r    <= 1'b0;
            prow_r   <= '1;
            pcnt_r   <= 3'h0;
        end else begin
            st_r     <= st_nxt;
            rq_r     <= rq_nxt;
            idx_r    <= idx_nxt;
            cnt_r    <= cnt_nxt;
            issued_r <= issued_nxt;
            cache_r  <= cache_nxt;
            stat_r   <= stat_nxt;
            err_r    <= err_nxt;
            rdd_r    <= rdd_nxt;
            rdv_r    <= rdv_nxt;
            prow_r   <= prow_nxt;
            pcnt_r   <= pcnt_nxt;
        end
    end

    assign req_ready    = (st_r == S_IDLE);
    assign req_error    = err_r;
    assign rd_data      = rdd_r;
    assign rd_valid     = rdv_r;
    assign status       = stat_r;
    assign status_valid = (st_r == S_DONE) && (rq_r.op == OP_STATUS || is_prog);
    assign busy         = (st_r != S_IDLE);
endmodule

// File: test/nand_seq_chk_sva.sv
`timescale 1ns/1ns
module nand_seq_chk
    import nand_host_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            sys_rst,
    input  nand_host_pkg::req_t  req,
    input  wire logic            req_valid,
    input  wire logic            req_ready,
    input  wire logic            req_error,
    input  wire logic [15:0]     rd_data,
    input  wire logic            rd_valid,
    input  wire logic            rd_ready,
    input  wire logic            status_valid,
    input  wire logic            busy,
    input  nand_host_pkg::pins_t pins
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic take;
    assign take = req_valid && req_ready;
    sequence s_wlo; !pins.we_n ##1 pins.we_n; endsequence
    sequence s_rlo; !pins.re_n ##1 pins.re_n; endsequence
    AST_WE_PULSE: assert property ($fell(pins.we_n) |=> s_wlo)
        else $error("write strobe width wrong");
    AST_RE_PULSE: assert property ($fell(pins.re_n) |=> s_rlo)
        else $error("read strobe width wrong");
    AST_NO_OVERLAP: assert property (!(!pins.we_n && !pins.re_n))
        else $error("both strobes low");
    AST_CLE_ALE: assert property (!(pins.cle && pins.ale))
        else $error("command and address latch together");
    AST_CLE_DRIVE: assert property (pins.cle |-> pins.dq_oe)
        else $error("command cycle not driven");
    AST_READ_FREE: assert property (!pins.re_n |-> !pins.dq_oe && !pins.cle)
        else $error("bus driven during read");
    AST_CACHE_COL: assert property (take && req.op == OP_CACHE_READ && req.col != 0 |=> req_error)
        else $error("cache read at nonzero column taken");
    AST_PROG_ZERO: assert property (take && req.op == OP_PROGRAM && req.count == 0 |=> req_error)
        else $error("empty program taken");
    AST_COPY_TOP: assert property (take && req.op == OP_COPY_BACK && req.five_addr
        && req.row[16] != req.dst_row[16] |=> req_error)
        else $error("copy back across top block bit taken");
    AST_RD_HOLD: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("read word dropped");
    AST_STAT_PULSE: assert property (status_valid |=> !status_valid)
        else $error("status pulse too long");
    AST_BUSY_REQ: assert property (busy |-> !req_ready)
        else $error("request accepted while busy");
endmodule
bind nand_page_op_sequencer nand_seq_chk u_nand_seq_chk (.clock(clock), .sys_rst(sys_rst),
    .req(req), .req_valid(req_valid), .req_ready(req_ready), .req_error(req_error),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .status_valid(status_valid), .busy(busy), .pins(pins));

// File: test/nand_flash_model.sv
`timescale 1ns/1ns
module nand_flash_model
    import nand_host_pkg::*;
#(
    parameter int BUSY_CYC = 12
) (
    input  wire logic            clock,
    input  nand_host_pkg::pins_t pins,
    output logic [15:0]          dq_in,
    output logic                 ready_busy_n
);
    logic        we_q   = 1'b1;
    logic        re_q   = 1'b1;
    logic        stat_m = 1'b0; // Power-up is array read.
    logic        fail   = 1'b0;
    logic [11:0] col    = 12'h000;
    logic [15:0] hold   = 16'h0000;
    logic [15:0] cur;
    logic [7:0]  d;
    int          bsy    = 0;
    int          ab     = 0;
    initial ready_busy_n = 1'b1;
    assign d = pins.dq_out[7:0];
    assign cur = stat_m ? {9'h000, ready_busy_n, ready_busy_n, 4'h0, fail} : {4'h0, col};
    assign dq_in = pins.re_n ? hold : cur;
    always @(posedge clock) begin
        we_q <= pins.we_n;
        re_q <= pins.re_n;
        if (!pins.re_n) hold <= cur;
        if (!pins.we_n) hold <= ~hold;
        if (bsy > 0) bsy <= bsy - 1;
        if (bsy == 1) ready_busy_n <= 1'b1;
        if (pins.re_n && !re_q && !stat_m) col <= col + 12'h001;
        if (pins.we_n && !we_q && pins.cle && (bsy == 0 || d == 8'h70 || d == 8'h34)) begin
            ab <= 0;
            stat_m <= (d == 8'h70 || d == 8'h10);
            if (d == 8'h30 || d == 8'h31 || d == 8'h34 || d == 8'h35 || d == 8'h10) begin
                ready_busy_n <= 1'b0;
                bsy <= BUSY_CYC;
            end
        end else if (pins.we_n && !we_q && pins.ale) begin
            ab <= ab + 1;
            if (ab == 0) col[7:0] <= d;
            if (ab == 1) col[11:8] <= d[3:0];
            if (ab == 2) fail <= (d == 8'hff);
        end
    end
endmodule

// File: test/nand_page_op_sequencer_tb_top.sv
`timescale 1ns/1ns
module nand_page_op_sequencer_tb_top;
    import nand_host_pkg::*;
    logic        clock, sys_rst, req_valid, req_ready, req_error, wr_valid, wr_ready;
    logic        rd_valid, rd_ready, status_valid, busy, ready_busy_n;
    logic [15:0] wr_data, rd_data, dq_in;
    logic [7:0]  status;
    logic [31:0] lfsr;
    req_t        req;
    pins_t       pins;
    logic [15:0] expq[$];
    int          mismatches, num_checks;
    nand_page_op_sequencer u_nand_page_op_sequencer (.clock(clock), .sys_rst(sys_rst),
        .req(req), .req_valid(req_valid), .req_ready(req_ready), .req_error(req_error),
        .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .status(status),
        .status_valid(status_valid), .busy(busy), .pins(pins), .dq_in(dq_in),
        .ready_busy_n(ready_busy_n));
    nand_flash_model u_nand_flash_model (.clock(clock), .pins(pins), .dq_in(dq_in),
        .ready_busy_n(ready_busy_n));
    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic req_t mk(op_t op, logic [11:0] c, logic [16:0] r, logic [16:0] t,
                                logic [11:0] n, logic f);
        return '{op: op, col: c, row: r, dst_row: t, count: n, five_addr: f, wide: 1'b0};
    endfunction
    always @(posedge clock) begin
        lfsr <= lfsr_next(lfsr);
        rd_ready <= lfsr[3] | lfsr[7];
        if (wr_ready) wr_data <= lfsr[15:0];
        if (wr_ready || !wr_valid) wr_valid <= lfsr[5] | lfsr[9];
    end
    ////////////////////////////////////////
    task end_sim;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got);
        logic [15:0] e;
        e = (expq.size() > 0) ? expq.pop_front() : 16'hdead;
        num_checks++;
        if (got !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    always @(posedge clock) begin
        if (!sys_rst && rd_valid && rd_ready) chk(rd_data);
        if (!sys_rst && status_valid) chk({8'h00, status});
        if (!sys_rst && req_error) chk(16'hfeed);
    end
    task automatic do_req(input req_t r);
        int n;
        @(posedge clock);
        req <= r;
        req_valid <= 1'b1;
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while ((busy !== 1'b0 || rd_valid !== 1'b0) && n < 20000);
        if (n >= 20000) chk(16'hb5b5);
        @(posedge clock);
    endtask
    task rd_exp(input logic [11:0] c, input int n);
        for (int i = 0; i < n; i++) expq.push_back({4'h0, c + 12'(i)});
    endtask
    ////////////////////////////////////////
    initial begin
        #900000;
        mismatches++;
        end_sim;
    end
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        wr_valid = 1'b1;
        wr_data = 16'h0000;
        rd_ready = 1'b0;
        lfsr = 32'h0611;
        mismatches = 0;
        num_checks = 0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        expq.push_back(16'h0060);
        do_req(mk(OP_STATUS, 0, 0, 0, 0, 0));
        rd_exp(12'h010, 4);
        do_req(mk(OP_READ, 12'h010, 17'h00123, 0, 4, 1));
        rd_exp(12'h100, 3);
        do_req(mk(OP_RAND_OUT, 12'h100, 0, 0, 3, 0));
        expq.push_back(16'hfeed);
        do_req(mk(OP_CACHE_READ, 12'h005, 17'h00200, 0, 2, 0));
        rd_exp(12'h000, 3);
        do_req(mk(OP_CACHE_READ, 0, 17'h00200, 0, 3, 0));
        expq.push_back(16'hfeed);
        do_req(mk(OP_RAND_OUT, 12'h004, 0, 0, 1, 0));
        do_req(mk(OP_CACHE_EXIT, 0, 0, 0, 0, 0));
        expq.push_back(16'hfeed);
        do_req(mk(OP_PROGRAM, 0, 17'h00300, 0, 0, 0));
        expq.push_back(16'hfeed);
        do_req(mk(OP_PROGRAM, 0, 17'h00300, 0, 12'd2113, 0));
        expq.push_back(16'hfeed);
        do_req('{OP_PROGRAM, 12'h000, 17'h00300, 17'h00000, 12'd1057, 1'b0, 1'b1});
        for (int i = 0; i <= MAX_PARTIAL; i++) begin
            expq.push_back((i < MAX_PARTIAL) ? 16'h0060 : 16'hfeed);
            do_req(mk(OP_PROGRAM, 0, 17'h00300, 0, (i == 0) ? 12'd2112 : 12'd1, 0));
        end
        expq.push_back(16'hfeed);
        do_req(mk(OP_COPY_BACK, 0, 17'h00010, 17'h10010, 0, 1));
        expq.push_back(16'h0061);
        do_req(mk(OP_COPY_BACK, 0, 17'h00010, 17'h000ff, 0, 0));
        do_req(mk(OP_RAND_IN, 0, 0, 0, 2, 0));
        expq.push_back(16'h0061);
        do_req(mk(OP_STATUS, 0, 0, 0, 0, 0));
        repeat (4) @(posedge clock);
        if (expq.size() != 0) chk(16'hc0c0);
        end_sim;
    end
endmodule
